// File: rtl/lpd_defines.vh
// Constants of the light and proximity readout block.
// Assumes inclusion by bare name from rtl/ sources only.
`ifndef LPD_DEFINES_VH
`define LPD_DEFINES_VH

// Register indices; byte address is four times the index
`define LPD_IDX_CONFIG 8'h00
`define LPD_IDX_LIGHT_HIGH_THRESHOLD 8'h01
`define LPD_IDX_LIGHT_LOW_THRESHOLD 8'h02
`define LPD_IDX_PROX_THRESHOLDS 8'h03
`define LPD_IDX_PROX_RESULT 8'h08
`define LPD_IDX_LIGHT_RESULT 8'h09
`define LPD_IDX_IRQ_FLAGS 8'h0B
`define LPD_IDX_IRQ_MASK 8'h0C

// Configuration fields
`define LPD_CFG_LIGHT_IRQ_ENABLE 0
`define LPD_CFG_PROX_IRQ_ENABLE 1
`define LPD_CFG_LIGHT_PERS_LSB 2
`define LPD_CFG_PROX_PERS_LSB 4
`define LPD_CFG_WIDTH 6
`define LPD_CFG_RESET 6'h03

// Flag byte positions, carried in data bits 15:8
`define LPD_FLAG_LSB 8
`define LPD_FLAG_PROTECT_LEAVE 7
`define LPD_FLAG_PROTECT_ENTER 6
`define LPD_FLAG_LIGHT_LOW 5
`define LPD_FLAG_LIGHT_HIGH 4
`define LPD_FLAG_PROX_CLOSE 1
`define LPD_FLAG_PROX_AWAY 0
`define LPD_FLAG_USED 8'hF3
`define LPD_MASK_RESET 8'hF3

// Threshold reset values
`define LPD_LIGHT_HIGH_RESET 16'hFFFF
`define LPD_LIGHT_LOW_RESET 16'h0000
`define LPD_PROX_HIGH_RESET 8'hFF
`define LPD_PROX_LOW_RESET 8'h00

`endif

// File: rtl/lpd_persist.v
// Consecutive-period filter for one threshold direction.
// Assumes sample_valid pulses once per integration period.
`default_nettype none

module lpd_persist #(
    parameter CW = 4
) (
    input wire pclk,
    input wire presetn,
    input wire sample_valid,
    input wire outside,
    input wire [CW-1:0] limit,
    output reg fire
);

reg [CW-1:0] count;
wire [CW-1:0] count_inc;

// Saturate at the limit, also when the limit is lowered mid-run
assign count_inc = (count >= limit) ? limit : count + {{(CW-1){1'b0}}, 1'b1};

always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        count <= {CW{1'b0}};
        fire <= 1'b0;
    end
    else
    begin
        fire <= 1'b0;
        if (sample_valid)
        begin
            if (outside)
            begin
                // Fires every period once the run is long enough
                count <= count_inc;
                fire <= (count_inc == limit);
            end
            else
            begin
                count <= {CW{1'b0}};
            end
        end
    end
end

endmodule

`default_nettype wire

// File: rtl/lpd_top.v
// Light and proximity readout, threshold compare and interrupt, APB slave.
// Assumes results arrive with one-cycle valid pulses synchronous to pclk.
// Assumes an external pull-up holds the interrupt pin high when released.
//
// Summary of operation
// - Every register reads back its contents
// - Light result is one 16-bit word
// - Proximity result read in one access
// - Enabled channel event pulls interrupt pin low
// - Registers stay accessible while interrupt asserted
// - Light event above high or below low
// - Proximity event above high or below low
// - Flag rising to one drives pin low
// - Flag read clears flags, pin returns high
// - Proximity between thresholds raises no event
// - Flag byte layout, bits 3:2 read zero
// - Light low byte low, high byte high
// - Proximity in low byte, high byte zero
// - Light event needs programmed consecutive periods
`default_nettype none
`include "lpd_defines.vh"

module lpd_top #(
    parameter AW = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [15:0] light_sample,
    input wire light_sample_valid,
    input wire [7:0] prox_sample,
    input wire prox_sample_valid,
    input wire prox_protect_enter,
    input wire prox_protect_leave,
    output reg irq,
    output reg int_pin_out,
    output reg int_pin_oe
);

// Byte address of a register index
function [AW-1:0] lpd_addr;
    input [7:0] idx;
    begin
        lpd_addr = {idx[AW-3:0], 2'b00};
    end
endfunction

// Persistence code to period count, 1/2/4/8 or 1..4
function [3:0] lpd_pers;
    input [1:0] code;
    input pow2;
    begin
        if (pow2)
            lpd_pers = 4'h1 << code;
        else
            lpd_pers = {2'b00, code} + 4'h1;
    end
endfunction

reg [`LPD_CFG_WIDTH-1:0] config_reg;
reg [15:0] light_high_threshold;
reg [15:0] light_low_threshold;
reg [7:0] proximity_high_threshold;
reg [7:0] proximity_low_threshold;
reg [15:0] light_result;
reg [7:0] proximity_result;
reg [7:0] irq_flags;
reg [7:0] irq_mask;
reg [7:0] returned_flags;
reg light_valid_d;
reg prox_valid_d;

reg [31:0] next_prdata;
reg next_pslverr;
reg [7:0] next_irq_flags;
reg [7:0] flag_set;
reg [7:0] flag_clear;

wire light_irq_enable;
wire proximity_irq_enable;
wire [3:0] light_persistence_count;
wire [3:0] prox_persistence_count;
wire light_high_fire;
wire light_low_fire;
wire prox_close_fire;
wire prox_away_fire;
wire wr_done;
wire rd_done;
wire flag_rd;

// Enables gate flag setting; the mask gates the pin
assign light_irq_enable = config_reg[`LPD_CFG_LIGHT_IRQ_ENABLE];
assign proximity_irq_enable = config_reg[`LPD_CFG_PROX_IRQ_ENABLE];
assign light_persistence_count = lpd_pers(config_reg[`LPD_CFG_LIGHT_PERS_LSB+1:`LPD_CFG_LIGHT_PERS_LSB], 1'b1);
assign prox_persistence_count = lpd_pers(config_reg[`LPD_CFG_PROX_PERS_LSB+1:`LPD_CFG_PROX_PERS_LSB], 1'b0);

// Transfer completes at the edge that samples pready high
assign wr_done = psel & penable & pready & pwrite;
assign rd_done = psel & penable & pready & ~pwrite;
// Read-clear acts on the snapshot the host was given
assign flag_rd = rd_done & (paddr == lpd_addr(`LPD_IDX_IRQ_FLAGS));

// Result capture, one cycle before the compare sees it
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        light_result <= 16'h0000;
        proximity_result <= 8'h00;
        light_valid_d <= 1'b0;
        prox_valid_d <= 1'b0;
    end
    else
    begin
        light_valid_d <= light_sample_valid;
        prox_valid_d <= prox_sample_valid;
        if (light_sample_valid)
            light_result <= light_sample;
        if (prox_sample_valid)
            proximity_result <= prox_sample;
    end
end

// Light window compare with persistence
lpd_persist #(
    .CW(4)
) u_light_high (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(light_valid_d),
    .outside(light_result > light_high_threshold),
    .limit(light_persistence_count),
    .fire(light_high_fire)
);

lpd_persist #(
    .CW(4)
) u_light_low (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(light_valid_d),
    .outside(light_result < light_low_threshold),
    .limit(light_persistence_count),
    .fire(light_low_fire)
);

// Proximity compare; values inside the window fire nothing
lpd_persist #(
    .CW(4)
) u_prox_close (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(prox_valid_d),
    .outside(proximity_result > proximity_high_threshold),
    .limit(prox_persistence_count),
    .fire(prox_close_fire)
);

lpd_persist #(
    .CW(4)
) u_prox_away (
    .pclk(pclk),
    .presetn(presetn),
    .sample_valid(prox_valid_d),
    .outside(proximity_result < proximity_low_threshold),
    .limit(prox_persistence_count),
    .fire(prox_away_fire)
);

// Flag set, read-clear and write-one-clear; set wins
always @*
begin
    flag_set = 8'h00;
    flag_set[`LPD_FLAG_LIGHT_HIGH] = light_high_fire & light_irq_enable;
    flag_set[`LPD_FLAG_LIGHT_LOW] = light_low_fire & light_irq_enable;
    flag_set[`LPD_FLAG_PROX_CLOSE] = prox_close_fire & proximity_irq_enable;
    flag_set[`LPD_FLAG_PROX_AWAY] = prox_away_fire & proximity_irq_enable;
    // Protection-mode events ride on the proximity enable
    flag_set[`LPD_FLAG_PROTECT_ENTER] = prox_protect_enter & proximity_irq_enable;
    flag_set[`LPD_FLAG_PROTECT_LEAVE] = prox_protect_leave & proximity_irq_enable;
    flag_clear = 8'h00;
    if (flag_rd)
        flag_clear = returned_flags;
    else if (wr_done && paddr == lpd_addr(`LPD_IDX_IRQ_FLAGS))
        flag_clear = pwdata[`LPD_FLAG_LSB+7:`LPD_FLAG_LSB];
    next_irq_flags = ((irq_flags & ~flag_clear) | flag_set) & `LPD_FLAG_USED;
end

// Read mux; every register reads back
always @*
begin
    next_prdata = 32'h00000000;
    next_pslverr = 1'b0;
    if (paddr == lpd_addr(`LPD_IDX_CONFIG))
        next_prdata[`LPD_CFG_WIDTH-1:0] = config_reg;
    else if (paddr == lpd_addr(`LPD_IDX_LIGHT_HIGH_THRESHOLD))
        next_prdata[15:0] = light_high_threshold;
    else if (paddr == lpd_addr(`LPD_IDX_LIGHT_LOW_THRESHOLD))
        next_prdata[15:0] = light_low_threshold;
    else if (paddr == lpd_addr(`LPD_IDX_PROX_THRESHOLDS))
        next_prdata[15:0] = {proximity_high_threshold, proximity_low_threshold};
    else if (paddr == lpd_addr(`LPD_IDX_PROX_RESULT))
        next_prdata[7:0] = proximity_result;
    else if (paddr == lpd_addr(`LPD_IDX_LIGHT_RESULT))
        next_prdata[15:0] = light_result;
    else if (paddr == lpd_addr(`LPD_IDX_IRQ_FLAGS))
        next_prdata[`LPD_FLAG_LSB+7:`LPD_FLAG_LSB] = irq_flags;
    else if (paddr == lpd_addr(`LPD_IDX_IRQ_MASK))
        next_prdata[`LPD_FLAG_LSB+7:`LPD_FLAG_LSB] = irq_mask;
    // Unmapped offsets answer with an error and zero data
    else
        next_pslverr = 1'b1;
end

// APB answer: one wait state, never held off by the interrupt
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        prdata <= 32'h00000000;
        pready <= 1'b0;
        pslverr <= 1'b0;
        returned_flags <= 8'h00;
    end
    else
    begin
        if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= next_pslverr;
            prdata <= pwrite ? 32'h00000000 : next_prdata;
            // Only the bits shown to the host are cleared
            returned_flags <= irq_flags;
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end
end

// Register writes at the completing edge
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        config_reg <= `LPD_CFG_RESET;
        light_high_threshold <= `LPD_LIGHT_HIGH_RESET;
        light_low_threshold <= `LPD_LIGHT_LOW_RESET;
        proximity_high_threshold <= `LPD_PROX_HIGH_RESET;
        proximity_low_threshold <= `LPD_PROX_LOW_RESET;
        irq_mask <= `LPD_MASK_RESET;
    end
    // Results are read-only; flag writes clear in the flag logic
    else if (wr_done)
    begin
        if (paddr == lpd_addr(`LPD_IDX_CONFIG))
            config_reg <= pwdata[`LPD_CFG_WIDTH-1:0];
        else if (paddr == lpd_addr(`LPD_IDX_LIGHT_HIGH_THRESHOLD))
            light_high_threshold <= pwdata[15:0];
        else if (paddr == lpd_addr(`LPD_IDX_LIGHT_LOW_THRESHOLD))
            light_low_threshold <= pwdata[15:0];
        else if (paddr == lpd_addr(`LPD_IDX_PROX_THRESHOLDS))
        begin
            proximity_low_threshold <= pwdata[7:0];
            proximity_high_threshold <= pwdata[15:8];
        end
        else if (paddr == lpd_addr(`LPD_IDX_IRQ_MASK))
            irq_mask <= pwdata[`LPD_FLAG_LSB+7:`LPD_FLAG_LSB] & `LPD_FLAG_USED;
    end
end

// Flags and interrupt outputs
always @(posedge pclk or negedge presetn)
begin
    if (!presetn)
    begin
        irq_flags <= 8'h00;
        irq <= 1'b0;
        int_pin_out <= 1'b0;
        int_pin_oe <= 1'b0;
    end
    else
    begin
        irq_flags <= next_irq_flags;
        // From the next flags, so the pin is released at the clearing edge
        irq <= |(next_irq_flags & irq_mask);
        int_pin_out <= 1'b0;
        // Open drain: drive low only while an unmasked flag stands
        int_pin_oe <= |(next_irq_flags & irq_mask);
    end
end

endmodule

`default_nettype wire

// File: testbench/lpd_checker_assertions.sv
// Checker for lpd_top: APB answer timing, read data layout, interrupt pin.
// Assumes binding to lpd_top, seeing its ports only.
`default_nettype none
module lpd_checker #(
    parameter AW = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [AW-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic light_sample_valid,
    input wire logic prox_sample_valid,
    input wire logic prox_protect_enter,
    input wire logic prox_protect_leave,
    input wire logic irq,
    input wire logic int_pin_out,
    input wire logic int_pin_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_done = psel && penable && pready && !pwrite && !pslverr;
    AST_PIN_FOLLOWS: assert property (int_pin_oe == irq)
        else $error("pin enable differs from irq");
    AST_PIN_LOW: assert property (int_pin_oe |-> !int_pin_out)
        else $error("pin driven high");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ANSWER: assert property (psel && penable && !pready |-> ##[1:2] pready)
        else $error("no answer to access");
    AST_ERR_READY: assert property (pslverr |-> pready)
        else $error("error without pready");
    AST_ERR_ZERO: assert property (pslverr |-> prdata == 32'h0)
        else $error("error answer carries data");
    AST_FLAG_BYTE: assert property (rd_done && paddr == 8'h2C |-> prdata[31:16] == 0 && prdata[11:10] == 0 && prdata[7:0] == 0)
        else $error("flag read has stray bits");
    AST_PROX_BYTE: assert property (rd_done && paddr == 8'h20 |-> prdata[31:8] == 0)
        else $error("proximity read has stray bits");
    AST_LIGHT_WORD: assert property (rd_done && paddr == 8'h24 |-> prdata[31:16] == 0)
        else $error("light read has stray bits");
    AST_IRQ_FALL: assert property ($fell(irq) |-> $past(psel && penable && pready && (pwrite || paddr == 8'h2C)))
        else $error("irq fell without flag service");
    AST_IRQ_RISE: assert property ($rose(irq) |-> $past(light_sample_valid, 3) || $past(prox_sample_valid, 3)
        || $past(prox_protect_enter) || $past(prox_protect_leave) || $past(prox_protect_enter, 2)
        || $past(prox_protect_leave, 2) || $past(pwrite && pready) || $past(pwrite && pready, 2))
        else $error("irq rose without cause");
endmodule
bind lpd_top lpd_checker #(.AW(AW)) u_lpd_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
    .pready, .pslverr, .light_sample_valid, .prox_sample_valid, .prox_protect_enter, .prox_protect_leave,
    .irq, .int_pin_out, .int_pin_oe);
`default_nettype wire

// File: testbench/lpd_host_model.sv
// Host model: APB master reading results and servicing the interrupt.
// Assumes pclk from the bench and a slave answering with pready.
`default_nettype none
module lpd_host_model (
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output var logic psel = 1'b0,
    output var logic penable = 1'b0,
    output var logic pwrite = 1'b0,
    output var logic [7:0] paddr = 8'h00,
    output var logic [31:0] pwdata = 32'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Whole word each transfer, light result fetched in one read
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] rd, output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle limit; the bench watchdog ends a hung wait
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~wd;
    endtask
endmodule
`default_nettype wire

// File: testbench/tb_light_proximity_data_and_interrupt.sv
// Testbench for lpd_top: host model drives APB, sensor samples driven here.
// Assumes design, checker and host model compiled first.
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("BAD %0t mismatch got %h want %h", $time, a, b); end end
`define RD(a, e) begin rg(a); `CHK(rd, e) end
module tb_light_proximity_data_and_interrupt;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 0, presetn = 0;
    logic [15:0] light_sample = 0;
    logic [7:0] prox_sample = 0;
    logic light_sample_valid = 0, prox_sample_valid = 0, prox_protect_enter = 0, prox_protect_leave = 0;
    wire logic psel, penable, pwrite, pready, pslverr, irq, int_pin_out, int_pin_oe;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic int_pin = int_pin_oe ? int_pin_out : 1'b1;
    int err_total = 0, checks = 0;
    logic [31:0] rd;
    logic er;
    logic [15:0] seed = 16'h839B, v;
    logic [15:0] corner[4] = '{16'h8000, 16'h8001, 16'h1000, 16'h0FFF};
    logic [7:0] pv[4] = '{8'h80, 8'hC0, 8'hC1, 8'h3F};
    logic [7:0] pf[4] = '{8'h00, 8'h00, 8'h02, 8'h01};
    always #50 pclk = ~pclk;
    lpd_top #(.AW(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .light_sample, .light_sample_valid, .prox_sample, .prox_sample_valid, .prox_protect_enter,
        .prox_protect_leave, .irq, .int_pin_out, .int_pin_oe);
    lpd_host_model HOST (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [7:0] lflag(input logic [15:0] s);
        return (s > 16'h8000) ? 8'h10 : (s < 16'h1000) ? 8'h20 : 8'h00;
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        HOST.xfer(1'b1, a, d, rd, er);
    endtask
    task automatic rg(input logic [7:0] a);
        HOST.xfer(1'b0, a, 32'h0, rd, er);
    endtask
    // Event kinds: 0 light, 1 proximity, 2 protect enter, 3 protect leave
    task automatic ev(input int k, input logic [15:0] s);
        @(posedge pclk);
        light_sample <= s;
        prox_sample <= s[7:0];
        light_sample_valid <= (k == 0);
        prox_sample_valid <= (k == 1);
        prox_protect_enter <= (k == 2);
        prox_protect_leave <= (k == 3);
        @(posedge pclk);
        {light_sample_valid, prox_sample_valid, prox_protect_enter, prox_protect_leave} <= 4'h0;
        repeat (3) @(posedge pclk);
    endtask
    task automatic print_verdict;
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #2000000;
        err_total++;
        print_verdict();
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        `RD(8'h00, 32'h3)
        `RD(8'h04, 32'hFFFF)
        `RD(8'h08, 32'h0)
        `RD(8'h30, 32'hF300)
        `RD(8'h2C, 32'h0)
        rg(8'h14);
        `CHK(er, 1'b1)
        wr(8'h04, 32'h8000);
        wr(8'h08, 32'h1000);
        wr(8'h0C, 32'hC040);
        `RD(8'h0C, 32'hC040)
        for (int i = 0; i < 44; i++)
        begin
            seed = lfsr(seed);
            v = (i < 4) ? corner[i] : seed;
            ev(0, v);
            `CHK(irq, |lflag(v))
            `CHK(int_pin, ~|lflag(v))
            `RD(8'h24, {16'h0, v})
            `RD(8'h2C, {16'h0, lflag(v), 8'h00})
            @(negedge pclk);
            `CHK(irq, 1'b0)
        end
        wr(8'h00, 32'hB);
        ev(0, 16'h4000);
        repeat (3) ev(0, 16'hFFFF);
        `CHK(irq, 1'b0)
        ev(0, 16'hFFFF);
        `CHK(irq, 1'b1)
        `RD(8'h2C, 32'h1000)
        wr(8'h00, 32'h3);
        ev(0, 16'hFFFF);
        `CHK(irq, 1'b1)
        `RD(8'h2C, 32'h1000)
        foreach (pv[i])
        begin
            ev(1, {8'h00, pv[i]});
            `RD(8'h20, {24'h0, pv[i]})
            `RD(8'h2C, {16'h0, pf[i], 8'h00})
        end
        for (int k = 2; k < 4; k++)
        begin
            ev(k, 16'h0);
            `RD(8'h2C, 32'h4000 << (k - 2))
        end
        wr(8'h30, 32'h0);
        ev(2, 16'h0);
        `CHK(int_pin, 1'b1)
        wr(8'h2C, 32'h4000);
        wr(8'h30, 32'hF300);
        `RD(8'h2C, 32'h0)
        wr(8'h00, 32'h0);
        ev(0, 16'hFFFF);
        `CHK(irq, 1'b0)
        `RD(8'h2C, 32'h0)
        print_verdict();
    end
endmodule
`default_nettype wire
